/* File: hw/pcc_top.sv */
`timescale 1ns/1ps
`include "pcc_regs.svh"

//Operation
// - Lock change requests interrupt when enabled
// - Manual mode: enable write ignored, reads 0
// - Lock toggle sets change flag in automatic mode only
// - Interrupt output equals flag and enable and automatic mode, registered
// - Manual mode: change flag reads 0
// - Control register read clears change flag
// - Reset: loop on, other control bits clear
// - Loop on bit enables loop and VCO
// - Loop cannot turn off while VCO selected
// - VCO select refused while loop off
// - Base clock is selected source halved
// - Output static three edges per source
// - Prescaler writes ignored while loop on
// - Prescaler field holds exponent directly
// - VCO range writes ignored while on
// - VCO range field holds exponent directly
// - Base clock twice bus rate, even duty
// - Reference clock buffers oscillator clock
// - Manual mode forces acquisition or tracking
// - Bandwidth mode bit: 1 auto, 0 manual
// - Zero linear range disables loop, deselects
module pcc_top
   import pcc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic oscillator_clock,
   input wire logic divided_vco_clock,
   input wire logic lockIndicator,
   input wire logic trackingActive,
   output logic base_clock_out,
   output logic loop_reference_clock,
   output logic loopEnable,
   output logic [1:0] prescaleExp,
   output logic [1:0] vcoRangeExp,
   output logic [7:0] vcoLinearRange,
   output logic bandwidthAuto,
   output logic trackForce,
   output logic lock_irq_request
);

   pcc_ctrl_t ctrl_q;
   logic autoMode_q;
   logic trackManual_q;
   logic [7:0] range_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic [2:0] oscSync_q;
   logic [2:0] pclkSync_q;
   logic [1:0] lockSync_q;
   logic [1:0] trackSync_q;
   logic lockPrev_q;
   logic refClk_q;
   logic baseOut_q;
   logic activeSel_q;
   pcc_sel_t selState_q;
   logic [1:0] edgeCnt_q;
   logic loopEn_q;
   logic irq_q;
   logic access;
   logic wrCtrl;
   logic wrBw;
   logic wrRange;
   logic rdCtrlDone;
   logic lockToggle;
   logic oscRise;
   logic pclkRise;
   logic oldRise;
   logic newRise;
   pcc_reg_t setupSel;
   pcc_reg_t accessSel;

   // Map a bus address onto a register
   function automatic pcc_reg_t regSel(input logic [11:0] addr);
      case (addr)
         `PCC_OFS_CTRL: regSel = PCC_REG_CTRL;
         `PCC_OFS_BW: regSel = PCC_REG_BW;
         `PCC_OFS_RANGE: regSel = PCC_REG_RANGE;
         default: regSel = PCC_REG_NONE;
      endcase
   endfunction

   // Bus decode and strobes
   assign setupSel = regSel(paddr);
   assign accessSel = setupSel;
   assign access = psel & penable & pready_q;
   assign wrCtrl = access & pwrite & (accessSel == PCC_REG_CTRL);
   assign wrBw = access & pwrite & (accessSel == PCC_REG_BW);
   assign wrRange = access & pwrite & (accessSel == PCC_REG_RANGE);
   // Clear only a flag that the read has shown
   assign rdCtrlDone = access & ~pwrite & (accessSel == PCC_REG_CTRL)
      & prdata_q[6];

   // No wait states: data prepared in the setup cycle
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= psel & ~penable;
         pslverr_q <= psel & ~penable & (setupSel == PCC_REG_NONE);
      end
   end

   // Read data, with mode dependent masking
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         prdata_q <= 32'h0;
      end else if (psel & ~penable & ~pwrite) begin
         case (setupSel)
            PCC_REG_CTRL: begin
               prdata_q <= {24'h0, ctrl_q.ie & autoMode_q,
                  ctrl_q.flag & autoMode_q,
                  ctrl_q.on, ctrl_q.baseSel, ctrl_q.pre, ctrl_q.vpr};
            end
            PCC_REG_BW: begin
               prdata_q <= {24'h0, autoMode_q,
                  lockSync_q[1] & autoMode_q,
                  autoMode_q ? trackSync_q[1] : trackManual_q,
                  5'h0};
            end
            PCC_REG_RANGE: begin
               prdata_q <= {24'h0, range_q};
            end
            default: begin
               prdata_q <= 32'h0;
            end
         endcase
      end
   end

   // Pin synchronisers; stage 0 feeds stage 1 only
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         oscSync_q <= 3'h0;
         pclkSync_q <= 3'h0;
         lockSync_q <= 2'h0;
         trackSync_q <= 2'h0;
      end else begin
         oscSync_q <= {oscSync_q[1:0], oscillator_clock};
         pclkSync_q <= {pclkSync_q[1:0], divided_vco_clock};
         lockSync_q <= {lockSync_q[0], lockIndicator};
         trackSync_q <= {trackSync_q[0], trackingActive};
      end
   end

   // Source rising edges as one-cycle enables
   assign oscRise = oscSync_q[1] & ~oscSync_q[2];
   assign pclkRise = pclkSync_q[1] & ~pclkSync_q[2];
   assign oldRise = activeSel_q ? pclkRise : oscRise;
   assign newRise = activeSel_q ? oscRise : pclkRise;

   // Lock edge detector, live only in automatic mode
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         lockPrev_q <= 1'b0;
      end else begin
         lockPrev_q <= lockSync_q[1];
      end
   end
   assign lockToggle = autoMode_q & (lockSync_q[1] ^ lockPrev_q);

   // Control register with its write protections
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ctrl_q <= pcc_ctrl_t'(`PCC_CTRL_RST);
      end else begin
         if (wrCtrl) begin
            if (autoMode_q) begin
               ctrl_q.ie <= pwdata[7];
            end
            // Old select bit guards the off request
            ctrl_q.on <= pwdata[5] | ctrl_q.baseSel;
            ctrl_q.baseSel <= pwdata[4] & ctrl_q.on;
            if (!ctrl_q.on) begin
               ctrl_q.pre <= pwdata[3:2];
               ctrl_q.vpr <= pwdata[1:0];
            end
         end
         if (range_q == 8'h0) begin
            ctrl_q.baseSel <= 1'b0;
         end
         // Set wins over the clearing read
         if (lockToggle) begin
            ctrl_q.flag <= 1'b1;
         end else if (rdCtrlDone) begin
            ctrl_q.flag <= 1'b0;
         end
      end
   end

   // Bandwidth mode and manual acquisition choice
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         autoMode_q <= 1'(`PCC_BW_RST >> `PCC_BW_AUTO);
         trackManual_q <= 1'(`PCC_BW_RST >> `PCC_BW_TRACK);
      end else if (wrBw) begin
         autoMode_q <= pwdata[`PCC_BW_AUTO];
         if (!autoMode_q) begin
            trackManual_q <= pwdata[`PCC_BW_TRACK];
         end
      end
   end

   // Linear range, writable only with loop off
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         range_q <= `PCC_RANGE_RST;
      end else if (wrRange && !ctrl_q.on) begin
         range_q <= pwdata[7:0];
      end
   end

   // Loop enable and interrupt request
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         loopEn_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         loopEn_q <= ctrl_q.on & (range_q != 8'h0);
         irq_q <= ctrl_q.flag & ctrl_q.ie & autoMode_q;
      end
   end

   // Reference clock is the resampled oscillator
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         refClk_q <= 1'b0;
      end else begin
         refClk_q <= oscSync_q[1];
      end
   end

   // Glitch-free selector: wait old edges, then new
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         selState_q <= PCC_SEL_IDLE;
         edgeCnt_q <= 2'h0;
         activeSel_q <= 1'b0;
      end else begin
         case (selState_q)
            PCC_SEL_IDLE: begin
               if (ctrl_q.baseSel != activeSel_q) begin
                  selState_q <= PCC_SEL_OLD;
                  edgeCnt_q <= 2'h0;
               end
            end
            PCC_SEL_OLD: begin
               if (oldRise) begin
                  if (edgeCnt_q == `PCC_SEL_EDGES - 2'h1) begin
                     selState_q <= PCC_SEL_NEW;
                     edgeCnt_q <= 2'h0;
                  end else begin
                     edgeCnt_q <= edgeCnt_q + 2'h1;
                  end
               end
            end
            PCC_SEL_NEW: begin
               if (newRise) begin
                  if (edgeCnt_q == `PCC_SEL_EDGES - 2'h1) begin
                     selState_q <= PCC_SEL_IDLE;
                     edgeCnt_q <= 2'h0;
                     activeSel_q <= ~activeSel_q;
                  end else begin
                     edgeCnt_q <= edgeCnt_q + 2'h1;
                  end
               end
            end
            default: begin
               selState_q <= PCC_SEL_IDLE;
               edgeCnt_q <= 2'h0;
            end
         endcase
      end
   end

   // Divide by two of the active source, held in stasis
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         baseOut_q <= 1'b0;
      end else if (selState_q == PCC_SEL_IDLE && oldRise) begin
         baseOut_q <= ~baseOut_q;
      end
   end

   // Outputs, each from a register
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign base_clock_out = baseOut_q;
   assign loop_reference_clock = refClk_q;
   assign loopEnable = loopEn_q;
   assign prescaleExp = ctrl_q.pre;
   assign vcoRangeExp = ctrl_q.vpr;
   assign vcoLinearRange = range_q;
   assign bandwidthAuto = autoMode_q;
   assign trackForce = trackManual_q;
   assign lock_irq_request = irq_q;

   // Checks beside the logic they guard
   a_irq_gate: assert property (@(posedge clk_sys)
      disable iff (reset) lock_irq_request |-> $past(ctrl_q.flag)
         && $past(ctrl_q.ie) && $past(autoMode_q))
      else $error("irq without flag and enable");

   a_irq_raise: assert property (@(posedge clk_sys)
      disable iff (reset) lockToggle && ctrl_q.ie ##1 ctrl_q.ie
         && autoMode_q |=> lock_irq_request)
      else $error("lock change gave no irq");

   a_flag_set: assert property (@(posedge clk_sys)
      disable iff (reset) lockToggle |=> ctrl_q.flag)
      else $error("lock toggle lost");

   a_flag_clear: assert property (@(posedge clk_sys)
      disable iff (reset) rdCtrlDone && !lockToggle |=> !ctrl_q.flag)
      else $error("read did not clear flag");

   a_ie_ignore: assert property (@(posedge clk_sys)
      disable iff (reset) wrCtrl && !autoMode_q |=> $stable(ctrl_q.ie))
      else $error("enable written in manual mode");

   a_on_hold: assert property (@(posedge clk_sys)
      disable iff (reset) wrCtrl && ctrl_q.baseSel |=> ctrl_q.on)
      else $error("loop turned off while selected");

   a_sel_refuse: assert property (@(posedge clk_sys)
      disable iff (reset) wrCtrl && !ctrl_q.on |=> !ctrl_q.baseSel)
      else $error("select set with loop off");

   a_pre_lock: assert property (@(posedge clk_sys)
      disable iff (reset) wrCtrl && ctrl_q.on |=> $stable(ctrl_q.pre))
      else $error("prescaler written while on");

   a_vpr_lock: assert property (@(posedge clk_sys)
      disable iff (reset) wrCtrl && ctrl_q.on |=> $stable(ctrl_q.vpr))
      else $error("range exponent written while on");

   a_base_stasis: assert property (@(posedge clk_sys)
      disable iff (reset)
      selState_q != PCC_SEL_IDLE |=> $stable(base_clock_out))
      else $error("base clock moved during switch");

   a_zero_range: assert property (@(posedge clk_sys)
      disable iff (reset)
      range_q == 8'h0 |=> !ctrl_q.baseSel && !loopEnable)
      else $error("zero range left loop selected");

   a_loop_on: assert property (@(posedge clk_sys)
      disable iff (reset)
      $rose(ctrl_q.on) && range_q != 8'h0 |=> loopEnable)
      else $error("loop enable did not follow");

endmodule

/* File: include/pcc_regs.svh */
`ifndef PCC_REGS_SVH
`define PCC_REGS_SVH

// Register byte offsets on the APB slave
`define PCC_OFS_CTRL 12'h000
`define PCC_OFS_BW 12'h004
`define PCC_OFS_RANGE 12'h008

// Bandwidth control field positions
`define PCC_BW_AUTO 7
`define PCC_BW_LOCK 6
`define PCC_BW_TRACK 5

// Reset values
`define PCC_CTRL_RST 8'h20
`define PCC_BW_RST 8'h00
`define PCC_RANGE_RST 8'h40

// Source edges waited on each side of a clock switch
`define PCC_SEL_EDGES 2'h3

`endif

/* File: include/pcc_pkg.sv */
package pcc_pkg;

   // Control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic ie;
      logic flag;
      logic on;
      logic baseSel;
      logic [1:0] pre;
      logic [1:0] vpr;
   } pcc_ctrl_t;

   // Register selected by an address
   typedef enum logic [1:0] {
      PCC_REG_NONE = 2'h0,
      PCC_REG_CTRL = 2'h1,
      PCC_REG_BW = 2'h2,
      PCC_REG_RANGE = 2'h3
   } pcc_reg_t;

   // Clock selector transition states, Gray ordered
   typedef enum logic [1:0] {
      PCC_SEL_IDLE = 2'b00,
      PCC_SEL_OLD = 2'b01,
      PCC_SEL_NEW = 2'b11
   } pcc_sel_t;

endpackage

/* File: testbench/pcc_bus_div.sv */
`timescale 1ns/1ps
// Bus clock stage fed by the base clock
module pcc_bus_div
   import pcc_pkg::*;
(
   input wire logic reset,
   input wire logic base_clock_out,
   output logic busClock,
   output logic [15:0] busRises
);
   // Bus clock is half the base clock
   always_ff @(posedge base_clock_out or posedge reset) begin
      if (reset) begin
         busClock <= 1'b0;
      end else begin
         busClock <= ~busClock;
      end
   end
   // Counts bus clock periods
   always_ff @(posedge busClock or posedge reset) begin
      if (reset) begin
         busRises <= 16'h0;
      end else begin
         busRises <= busRises + 16'h1;
      end
   end
endmodule

/* File: testbench/pll_control_clock_select_tb_top.sv */
`timescale 1ns/1ps
`include "pcc_regs.svh"
module pll_control_clock_select_tb_top
   import pcc_pkg::*;
;
   localparam logic [11:0] CA = `PCC_OFS_CTRL;
   localparam logic [11:0] BA = `PCC_OFS_BW;
   localparam logic [11:0] RA = `PCC_OFS_RANGE;
   logic clk_sys, reset, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic oscillator_clock = 1'b0;
   logic divided_vco_clock = 1'b0;
   logic lockIndicator, trackingActive, base_clock_out;
   logic loop_reference_clock, loopEnable, bandwidthAuto;
   logic trackForce, lock_irq_request, busClock;
   logic [1:0] prescaleExp, vcoRangeExp, p, v;
   logic [7:0] vcoLinearRange, rv;
   logic [15:0] busRises;
   logic [2:0] oscHist;
   int fail_count, n_compared;
   int tick = 0;

   pcc_top i_dut (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .oscillator_clock,
      .divided_vco_clock, .lockIndicator, .trackingActive,
      .base_clock_out, .loop_reference_clock, .loopEnable, .prescaleExp,
      .vcoRangeExp, .vcoLinearRange, .bandwidthAuto, .trackForce,
      .lock_irq_request);
   pcc_bus_div i_bus (.reset, .base_clock_out, .busClock, .busRises);

   // System clock
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   // Slow source clocks and oscillator history
   always @(posedge clk_sys) begin
      tick <= tick + 1;
      oscillator_clock <= 1'((tick / 5) % 2);
      divided_vco_clock <= 1'((tick / 7) % 2);
      oscHist <= {oscHist[1:0], oscillator_clock};
   end

   task automatic stop_test();
      $display("compared %0d failed %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // One APB transfer, held until pready
   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [7:0] d, output logic [32:0] r);
      int n;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      // Values read here are those sampled at this edge
      @(posedge clk_sys);
      while (pready !== 1'b1) begin
         n++;
         if (n > 8) begin
            fail_count++;
            stop_test();
         end
         @(posedge clk_sys);
      end
      r = {pslverr, prdata};
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [32:0] r;
      apb(1'b1, a, d, r);
      @(negedge clk_sys); // Let the write settle before checks
   endtask

   task automatic rdc(input logic [11:0] a, input logic [32:0] exp);
      logic [32:0] r;
      apb(1'b0, a, 8'h0, r);
      chk(r, exp);
   endtask

   function automatic logic [32:0] ctl(input logic ie, fl, on, sel,
      input logic [1:0] pre, vpr);
      pcc_ctrl_t c;
      c = '{ie, fl, on, sel, pre, vpr};
      return {25'h0, c};
   endfunction

   task automatic tog();
      @(posedge clk_sys);
      lockIndicator <= ~lockIndicator;
      repeat (6) @(posedge clk_sys);
   endtask

   // Base clock must not move while switching
   task automatic stat();
      logic b;
      int ch;
      // Let the last old-source toggle land first
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      b = base_clock_out;
      ch = 0;
      repeat (30) begin
         @(negedge clk_sys);
         if (base_clock_out !== b) ch++;
      end
      chk(33'(ch), 33'h0);
   endtask

   // Bus periods counted in a fixed window
   task automatic rate(input int lo, input int hi);
      int d;
      repeat (80) @(posedge clk_sys);
      d = busRises;
      repeat (600) @(posedge clk_sys);
      d = busRises - d;
      chk(33'(d >= lo && d <= hi), 33'h1);
   endtask

   // Main sequence
   initial begin
      fail_count = 0;
      n_compared = 0;
      reset = 1'b1;
      {psel, penable, pwrite, lockIndicator, trackingActive} = '0;
      paddr = '0;
      pwdata = '0;
      void'($urandom(73154));
      repeat (20) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      rdc(CA, ctl('0, '0, '1, '0, '0, '0));
      rdc(BA, 33'h0);
      rdc(12'h00c, 33'h1_0000_0000);
      chk(33'(loopEnable), 33'h1);
      wr(CA, 8'ha0);
      rdc(CA, 33'h20);
      tog();
      rdc(CA, 33'h20);
      chk(33'(lock_irq_request), 33'h0);
      wr(CA, 8'h2e);
      rdc(CA, 33'h20);
      wr(RA, 8'h12);
      rdc(RA, 33'h40);
      rate(14, 16);
      wr(CA, 8'h30);
      stat();
      rate(10, 11);
      wr(CA, 8'h10);
      rdc(CA, 33'h30);
      wr(CA, 8'h20);
      stat();
      wr(CA, 8'h00);
      repeat (2) @(posedge clk_sys);
      chk(33'(loopEnable), 33'h0);
      wr(CA, 8'h10);
      rdc(CA, 33'h00);
      wr(CA, 8'h30);
      rdc(CA, 33'h20);
      wr(CA, 8'h00);
      for (int i = 0; i < 4; i++) begin
         p = 2'(i);
         v = 2'(i % 3);
         wr(CA, {4'h0, p, v});
         rdc(CA, ctl('0, '0, '0, '0, p, v));
         chk(33'({prescaleExp, vcoRangeExp}), 33'({p, v}));
      end
      wr(CA, 8'h00);
      wr(RA, 8'h00);
      wr(CA, 8'h20);
      wr(CA, 8'h30);
      rdc(CA, 33'h20);
      chk(33'(loopEnable), 33'h0);
      wr(CA, 8'h00);
      rv = 8'($urandom_range(1, 255));
      wr(RA, rv);
      chk(33'(vcoLinearRange), 33'(rv));
      wr(BA, 8'h80);
      chk(33'(bandwidthAuto), 33'h1);
      @(posedge clk_sys);
      trackingActive <= 1'($urandom % 2);
      repeat (6) @(posedge clk_sys);
      rdc(BA, {25'h0, 1'b1, lockIndicator, trackingActive, 5'h0});
      wr(CA, 8'h80);
      tog();
      chk(33'(lock_irq_request), 33'h1);
      rdc(CA, 33'hc0);
      rdc(CA, 33'h80);
      repeat (2) @(posedge clk_sys);
      chk(33'(lock_irq_request), 33'h0);
      wr(CA, 8'h00);
      tog();
      chk(33'(lock_irq_request), 33'h0);
      rdc(CA, 33'h40);
      wr(BA, 8'h20);
      chk(33'(bandwidthAuto), 33'h0);
      wr(BA, 8'h20);
      chk(33'(trackForce), 33'h1);
      rdc(BA, 33'h20);
      repeat (40) begin
         @(negedge clk_sys);
         chk(33'(loop_reference_clock), 33'(oscHist[2]));
      end
      stop_test();
   end
endmodule
